// ===== pmc_regs.vh
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ==========================================================
// Register byte offsets
`define PMC_AW 8
`define PMC_DW 32
`define PMC_OFS_MODE 8'h00
`define PMC_OFS_SAVED 8'h04
`define PMC_OFS_CFG 8'h08
`define PMC_OFS_URIGHTS 8'h0C
`define PMC_OFS_CL_LO 8'h10
`define PMC_OFS_CL_HI 8'h14
`define PMC_OFS_SUBMODE 8'h18
`define PMC_OFS_INT_STAT 8'h1C
`define PMC_OFS_INT_MASK 8'h20

// ==========================================================
// Mode flags: bit 1 super-system, bit 0 system
`define PMC_SSM_BIT 1
`define PMC_SM_BIT 0
`define PMC_MODE_USER 2'h0
`define PMC_MODE_SM_MASK 2'h1
`define PMC_MODE_RESET 2'h2
`define PMC_SUB_BOOT 2'h0
`define PMC_SUB_TEST 2'h1
`define PMC_SUB_CL 2'h2
`define PMC_SUB_RSVD 2'h3

// ==========================================================
// Fields and values
`define PMC_CFG_IRQ_SYS_BIT 0
`define PMC_CFG_RESET 1'h1
`define PMC_RIGHTS_W 16
`define PMC_RIGHTS_ALL 16'hFFFF
`define PMC_RIGHTS_RESET 16'h0000
`define PMC_CL_W 8
`define PMC_CL_RESET 8'h00
`define PMC_GROUP_W 4
`define PMC_ADDR_W 24
`define PMC_USER_ENTRY_ADDR 24'h800000
`define PMC_INT_W 3
`define PMC_INT_EXC 0
`define PMC_INT_UENT 1
`define PMC_INT_DENY 2
`define PMC_INT_RESET 3'h0
`define PMC_DENY_VALUE 32'h00000000
`define PMC_ZERO32 32'h00000000

`endif

// ===== pmc_access_gate.v
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_access_gate
(
  input wire [1:0] mode_flags,
  input wire [1:0] super_mode,
  input wire [`PMC_RIGHTS_W-1:0] user_rights,
  input wire [`PMC_CL_W-1:0] cl_rights_lo,
  input wire [`PMC_CL_W-1:0] cl_rights_hi,
  input wire [`PMC_GROUP_W-1:0] group,
  output wire allowed
);

  reg [`PMC_RIGHTS_W-1:0] rights;

  // ==========================================================
  // Rights vector by mode
  always @*
  begin
    if (mode_flags[`PMC_SSM_BIT])
    begin
      if (super_mode == `PMC_SUB_CL)
        rights = {cl_rights_hi, cl_rights_lo}; // [RULE16]
      else
        rights = `PMC_RIGHTS_ALL; // [RULE16]
    end
    else if (mode_flags[`PMC_SM_BIT])
      rights = `PMC_RIGHTS_ALL; // [RULE13]
    else
      rights = user_rights; // [RULE12]
  end

  assign allowed = rights[group]; // [RULE12]

endmodule // pmc_access_gate

`default_nettype wire

// ===== pmc_mode_ctrl.v
// Operation
// [RULE1] Two mode flags, super-system and system, are kept; both clear means user mode.
// [RULE2] With the super-system flag set the CPU is in boot, test or contactless mode.
// [RULE3] A system vector call sets the system flag.
// [RULE4] A system vector call is accepted only in user mode, otherwise it raises an exception.
// [RULE5] Every exception entry sets the system flag before its handler runs.
// [RULE6] System software chooses whether interrupts run in user or system mode.
// [RULE7] A return from interrupt restores the mode flags saved at entry.
// [RULE8] In user mode a return is legal only with user-mode interrupts and one active.
// [RULE9] A long, absolute or extended call to 0x800000 in system mode enters user mode.
// [RULE10] That user entry call pushes no return address, unlike a vector call.
// [RULE11] Direct writes can only clear the mode flags, never set them.
// [RULE12] In user or contactless mode a peripheral group is usable only if granted.
// [RULE13] System mode reaches all peripheral and system-management registers; here it cannot write the sub-mode register.
// [RULE14] Application software cannot enter boot, test or contactless mode.
// [RULE15] A forbidden register access is ignored and reads a fixed value.
// [RULE16] Boot, test and system see full rights; contactless uses two locked registers.
// [RULE17] Reset leaves the super-system flag set, in boot mode.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_mode_ctrl
(
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PMC_AW-1:0] paddr,
  input wire [`PMC_DW-1:0] pwdata,
  output reg [`PMC_DW-1:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire core_system_vector_call_call,
  input wire core_exception,
  input wire core_irq_entry,
  input wire core_irq_active,
  input wire core_return_from_interrupt,
  input wire core_far_call,
  input wire [`PMC_ADDR_W-1:0] core_call_addr,
  input wire core_mode_wr,
  input wire [1:0] core_mode_wdata,
  input wire per_req,
  input wire [`PMC_GROUP_W-1:0] per_group,
  output reg per_grant,
  output reg per_deny,
  output reg [1:0] mode_flags,
  output reg [1:0] super_mode,
  output reg exc_raise,
  output reg push_return,
  output reg user_entry,
  output reg irq
);

  // ==========================================================
  // Mode decode helpers
  function f_is_user;
    input [1:0] m;
    begin
      f_is_user = (m == `PMC_MODE_USER); // [RULE1]
    end
  endfunction

  function f_is_system;
    input [1:0] m;
    begin
      f_is_system = m[`PMC_SM_BIT] & ~m[`PMC_SSM_BIT];
    end
  endfunction

  function f_is_super;
    input [1:0] m;
    begin
      f_is_super = m[`PMC_SSM_BIT];
    end
  endfunction

  // ==========================================================
  // State
  reg [1:0] saved_mode;
  reg irq_in_system;
  reg [`PMC_RIGHTS_W-1:0] user_rights;
  reg [`PMC_CL_W-1:0] cl_rights_lo;
  reg [`PMC_CL_W-1:0] cl_rights_hi;
  reg [`PMC_INT_W-1:0] int_status;
  reg [`PMC_INT_W-1:0] int_mask;

  reg [1:0] next_mode;
  reg [1:0] next_saved;
  reg next_exc;
  reg next_push;
  reg next_uent;
  reg violation;

  wire per_allowed;
  wire apb_setup_access;
  wire apb_commit;
  wire apb_wr;
  reg addr_ok;
  reg priv_ok;
  reg [`PMC_DW-1:0] rd_value;
  wire in_user;
  wire in_cl;
  wire in_super;

  assign in_user = f_is_user(mode_flags);
  assign in_super = f_is_super(mode_flags);
  assign in_cl = in_super & (super_mode == `PMC_SUB_CL);

  // Access phase before the answer; commit is the cycle pready is high
  assign apb_setup_access = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready;
  assign apb_wr = apb_commit & pwrite & addr_ok & priv_ok;

  // ==========================================================
  // Peripheral rights
  pmc_access_gate u_gate
  (
    .mode_flags(mode_flags),
    .super_mode(super_mode),
    .user_rights(user_rights),
    .cl_rights_lo(cl_rights_lo),
    .cl_rights_hi(cl_rights_hi),
    .group(per_group),
    .allowed(per_allowed)
  );

  // ==========================================================
  // Address decode and privilege check
  always @*
  begin
    addr_ok = 1'b1;
    priv_ok = ~in_user; // [RULE13]
    case (paddr)
      `PMC_OFS_MODE: priv_ok = 1'b1;
      `PMC_OFS_SAVED: priv_ok = ~in_user;
      `PMC_OFS_CFG: priv_ok = ~in_user;
      `PMC_OFS_URIGHTS: priv_ok = ~in_user;
      `PMC_OFS_CL_LO: priv_ok = ~in_user & ~(in_cl & pwrite); // [RULE16]
      `PMC_OFS_CL_HI: priv_ok = ~in_user & ~(in_cl & pwrite); // [RULE16]
      `PMC_OFS_SUBMODE: priv_ok = in_super | ~pwrite; // [RULE14]
      `PMC_OFS_INT_STAT: priv_ok = ~in_user;
      `PMC_OFS_INT_MASK: priv_ok = ~in_user;
      default: addr_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Read mux
  always @*
  begin
    rd_value = `PMC_ZERO32;
    case (paddr)
      `PMC_OFS_MODE: rd_value[1:0] = mode_flags;
      `PMC_OFS_SAVED: rd_value[1:0] = saved_mode;
      `PMC_OFS_CFG: rd_value[`PMC_CFG_IRQ_SYS_BIT] = irq_in_system;
      `PMC_OFS_URIGHTS: rd_value[`PMC_RIGHTS_W-1:0] = user_rights;
      `PMC_OFS_CL_LO: rd_value[`PMC_CL_W-1:0] = cl_rights_lo;
      `PMC_OFS_CL_HI: rd_value[`PMC_CL_W-1:0] = cl_rights_hi;
      `PMC_OFS_SUBMODE: rd_value[1:0] = super_mode;
      `PMC_OFS_INT_STAT: rd_value[`PMC_INT_W-1:0] = int_status;
      `PMC_OFS_INT_MASK: rd_value[`PMC_INT_W-1:0] = int_mask;
      default: rd_value = `PMC_ZERO32;
    endcase
    // A fixed value on denial keeps register contents from leaking to user code
    if (~priv_ok)
      rd_value = `PMC_DENY_VALUE; // [RULE15]
  end

  // ==========================================================
  // Mode transitions
  // One core event per cycle is expected; the chain gives exceptions
  // priority so a handler entry is never lost behind a lesser event.
  always @*
  begin
    next_mode = mode_flags;
    next_saved = saved_mode;
    next_exc = 1'b0;
    next_push = 1'b0;
    next_uent = 1'b0;
    violation = 1'b0;
    if (core_exception)
    begin
      next_saved = mode_flags;
      next_mode = mode_flags | `PMC_MODE_SM_MASK; // [RULE5]
    end
    else if (core_irq_entry)
    begin
      next_saved = mode_flags;
      if (irq_in_system)
        next_mode = mode_flags | `PMC_MODE_SM_MASK; // [RULE6]
    end
    else if (core_system_vector_call_call)
    begin
      if (in_user) // [RULE4]
      begin
        next_saved = mode_flags;
        next_mode = mode_flags | `PMC_MODE_SM_MASK; // [RULE3]
        next_push = 1'b1;
      end
      else
        violation = 1'b1; // [RULE4]
    end
    else if (core_return_from_interrupt)
    begin
      if (in_user & ~(~irq_in_system & core_irq_active))
        violation = 1'b1; // [RULE8]
      else
        next_mode = saved_mode; // [RULE7]
    end
    else if (core_far_call & (core_call_addr == `PMC_USER_ENTRY_ADDR)
             & f_is_system(mode_flags))
    begin
      next_mode = `PMC_MODE_USER; // [RULE9]
      next_uent = 1'b1; // [RULE10]
    end
    else if (core_mode_wr)
      next_mode = mode_flags & core_mode_wdata; // [RULE11]
    else if (apb_wr & (paddr == `PMC_OFS_MODE))
      next_mode = mode_flags & pwdata[1:0]; // [RULE11]
    if (violation)
    begin
      next_saved = mode_flags;
      next_mode = mode_flags | `PMC_MODE_SM_MASK; // [RULE5]
      next_exc = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      mode_flags <= `PMC_MODE_RESET; // [RULE17]
      super_mode <= `PMC_SUB_BOOT; // [RULE2]
      saved_mode <= `PMC_MODE_RESET;
      exc_raise <= 1'b0;
      push_return <= 1'b0;
      user_entry <= 1'b0;
      irq_in_system <= `PMC_CFG_RESET;
      user_rights <= `PMC_RIGHTS_RESET;
      cl_rights_lo <= `PMC_CL_RESET;
      cl_rights_hi <= `PMC_CL_RESET;
      int_status <= `PMC_INT_RESET;
      int_mask <= `PMC_INT_RESET;
      per_grant <= 1'b0;
      per_deny <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PMC_ZERO32;
      irq <= 1'b0;
    end
    else
    begin
      mode_flags <= next_mode; // [RULE1]
      saved_mode <= next_saved;
      exc_raise <= next_exc;
      push_return <= next_push; // [RULE10]
      user_entry <= next_uent;
      per_grant <= per_req & per_allowed; // [RULE12]
      per_deny <= per_req & ~per_allowed;
      pready <= apb_setup_access;
      pslverr <= apb_setup_access & ~addr_ok;
      prdata <= apb_setup_access ? rd_value : `PMC_ZERO32;
      if (apb_wr)
      begin
        case (paddr)
          `PMC_OFS_CFG: irq_in_system <= pwdata[`PMC_CFG_IRQ_SYS_BIT]; // [RULE6]
          `PMC_OFS_URIGHTS: user_rights <= pwdata[`PMC_RIGHTS_W-1:0];
          `PMC_OFS_CL_LO: cl_rights_lo <= pwdata[`PMC_CL_W-1:0]; // [RULE16]
          `PMC_OFS_CL_HI: cl_rights_hi <= pwdata[`PMC_CL_W-1:0]; // [RULE16]
          `PMC_OFS_SUBMODE:
          begin
            // Only firmware already in a super mode may pick the sub-mode
            if (pwdata[1:0] != `PMC_SUB_RSVD)
              super_mode <= pwdata[1:0]; // [RULE14]
          end
          `PMC_OFS_INT_MASK: int_mask <= pwdata[`PMC_INT_W-1:0];
          default: super_mode <= super_mode;
        endcase
      end
      // Set wins over a write-one clear in the same cycle
      int_status <= (int_status
                     & ~((apb_wr & (paddr == `PMC_OFS_INT_STAT))
                         ? pwdata[`PMC_INT_W-1:0] : `PMC_INT_RESET))
                    | {(per_req & ~per_allowed)
                       | (apb_commit & addr_ok & ~priv_ok),
                       next_uent, next_exc};
      irq <= |(int_status & int_mask);
    end
  end

endmodule // pmc_mode_ctrl

`default_nettype wire

// ===== pmc_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs.vh"
// ==========
// Port checker
module pmc_checker
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic penable,
  input wire logic core_exception,
  input wire logic core_irq_entry,
  input wire logic core_system_vector_call_call,
  input wire logic core_return_from_interrupt,
  input wire logic core_far_call,
  input wire logic [`PMC_ADDR_W-1:0] core_call_addr,
  input wire logic per_req,
  input wire logic per_grant,
  input wire logic [1:0] mode_flags,
  input wire logic pready,
  input wire logic exc_raise,
  input wire logic push_return,
  input wire logic user_entry
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Higher-priority events drop the lower ones in the same cycle
  wire calm = !core_exception && !core_irq_entry;
  AST_RESET: assert property ($rose(resetn) |-> mode_flags == 2'h2)
    else $error("reset mode");
  AST_SYSTEM_VECTOR_CALL: assert property (calm && core_system_vector_call_call && mode_flags == 2'h0
    |=> mode_flags == 2'h1 && push_return) else $error("system_vector_call entry");
  AST_SYSTEM_VECTOR_CALL_BAD: assert property (calm && core_system_vector_call_call && mode_flags != 2'h0
    |=> exc_raise && !push_return && mode_flags[0]) else $error("system_vector_call refusal");
  AST_EXC: assert property (core_exception |=> mode_flags[0])
    else $error("exception entry");
  AST_UENT: assert property (calm && !core_system_vector_call_call && !core_return_from_interrupt
    && core_far_call && core_call_addr == `PMC_USER_ENTRY_ADDR && mode_flags == 2'h1
    |=> mode_flags == 2'h0 && user_entry && !push_return) else $error("user entry");
  AST_NO_RAISE: assert property (calm && !core_system_vector_call_call && !core_return_from_interrupt
    |=> (mode_flags & ~$past(mode_flags)) == 2'h0) else $error("flag raised");
  AST_SYS_GRANT: assert property (per_req && mode_flags == 2'h1 |=> per_grant)
    else $error("system grant");
  AST_READY: assert property ($rose(penable) |=> pready ##1 !pready)
    else $error("ready timing");
endmodule // pmc_checker
bind pmc_mode_ctrl pmc_checker chk (.mclk, .resetn, .penable, .core_exception,
  .core_irq_entry, .core_system_vector_call_call, .core_return_from_interrupt, .core_far_call, .core_call_addr,
  .per_req, .per_grant, .mode_flags, .pready, .exc_raise, .push_return, .user_entry);
`default_nettype wire

// ===== pmc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Core side: one event pulse per call
module pmc_core_model
(
  input wire logic mclk,
  output logic [6:0] ev = 7'h00,
  output logic [23:0] ca = 24'h000000,
  output logic act = 1'b0
);
  // Idle lines carry flipped data so a stale value never looks valid
  task fire(input int k, input logic [23:0] a, input logic at);
    @(posedge mclk);
    ev <= 7'h40 >> k;
    ca <= a;
    act <= at;
    @(posedge mclk);
    ev <= 7'h00;
    ca <= ~a;
    act <= ~at;
    @(negedge mclk);
  endtask
endmodule // pmc_core_model
`default_nettype wire

// ===== cpu_privilege_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("[FAIL] %s %0h %0h", n, e, g); n_fail++; end end
// ==========
// Bench top
module cpu_privilege_mode_control_tb;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, r;
  int n_fail = 0, n_tests = 0;
  wire [31:0] prdata;
  wire [23:0] ca;
  wire [6:0] ev;
  wire [1:0] mode_flags, super_mode;
  wire act, pready, pslverr, per_grant, per_deny, exc_raise, push_return, user_entry, irq;
  always #12.5 mclk = ~mclk;
  pmc_core_model core (.mclk, .ev, .ca, .act);
  pmc_mode_ctrl dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_exception(ev[6]), .core_irq_entry(ev[5]), .core_system_vector_call_call(ev[4]),
    .core_return_from_interrupt(ev[3]), .core_far_call(ev[2]), .core_mode_wr(ev[1]), .per_req(ev[0]),
    .core_call_addr(ca), .core_mode_wdata(ca[1:0]), .per_group(ca[3:0]), .core_irq_active(act),
    .per_grant, .per_deny, .mode_flags, .super_mode, .exc_raise, .push_return, .user_entry, .irq);
  task stop_test();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      n_fail++;
      stop_test();
    end
    @(negedge mclk);
  endtask
  // Expected grant of one group from the rights word written for it
  function automatic logic exp_grant(input logic [15:0] rights, input int g);
    return rights[g];
  endfunction
  // Direct writes may only clear mode flags
  function automatic logic [1:0] exp_clear(input logic [1:0] m, input logic [1:0] w);
    return m & w;
  endfunction
  initial
  begin
    void'($urandom(49172));
    r = $urandom | 32'h1;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    `CHK("mode", 2'h2, mode_flags)
    apb(1'b0, `PMC_OFS_CFG, 0);
    `CHK("cfg", 32'h1, q)
    apb(1'b0, 8'h40, 0);
    `CHK("unmapped", 1'b1, e)
    core.fire(6, 24'($urandom), 1'b0);
    `CHK("boot", 1'b1, per_grant)
    apb(1'b1, `PMC_OFS_CL_LO, 32'h5);
    apb(1'b1, `PMC_OFS_SUBMODE, 32'h2);
    apb(1'b1, `PMC_OFS_CL_LO, 32'hFF);
    `CHK("sub", 2'h2, super_mode)
    for (int g = 0; g < 2; g++)
    begin
      core.fire(6, 24'(g), 1'b0);
      `CHK("cl", exp_grant(16'h0005, g), per_grant)
      `CHK("cl deny", !exp_grant(16'h0005, g), per_deny)
    end
    core.fire(0, 24'h0, 1'b0);
    `CHK("exc", 2'h3, mode_flags)
    core.fire(5, 24'h1, 1'b0);
    `CHK("clr", exp_clear(2'h3, 2'h1), mode_flags)
    core.fire(6, 24'hF, 1'b0);
    `CHK("sys", 1'b1, per_grant)
    core.fire(2, 24'h0, 1'b0);
    `CHK("system_vector_call sys", 1'b1, exc_raise)
    apb(1'b1, `PMC_OFS_URIGHTS, r);
    apb(1'b1, `PMC_OFS_INT_MASK, 32'h7);
    core.fire(4, 24'($urandom) & 24'h7FFFFF, 1'b0);
    `CHK("call", 2'h1, mode_flags)
    core.fire(4, `PMC_USER_ENTRY_ADDR, 1'b0);
    `CHK("uent", 4'h8, {user_entry, push_return, mode_flags})
    for (int g = 0; g < 16; g++)
    begin
      core.fire(6, 24'(g), 1'b0);
      `CHK("rights", exp_grant(r[15:0], g), per_grant)
      `CHK("no rights", !exp_grant(r[15:0], g), per_deny)
    end
    apb(1'b0, `PMC_OFS_URIGHTS, 0);
    `CHK("deny", `PMC_DENY_VALUE, q)
    apb(1'b1, `PMC_OFS_MODE, 32'h3);
    `CHK("no raise", exp_clear(2'h0, 2'h3), mode_flags)
    core.fire(1, 24'h0, 1'b1);
    `CHK("irq sys", 2'h1, mode_flags)
    core.fire(3, 24'h0, 1'b0);
    `CHK("return_from_interrupt", 2'h0, mode_flags)
    core.fire(3, 24'h0, 1'b1);
    `CHK("return_from_interrupt usr", 3'h5, {exc_raise, mode_flags})
    apb(1'b1, `PMC_OFS_CFG, 0);
    core.fire(5, 24'h0, 1'b0);
    core.fire(1, 24'h0, 1'b1);
    `CHK("irq usr", 2'h0, mode_flags)
    core.fire(3, 24'h0, 1'b1);
    `CHK("return_from_interrupt ok", 3'h0, {exc_raise, mode_flags})
    core.fire(2, 24'h0, 1'b0);
    `CHK("system_vector_call", 3'h5, {push_return, mode_flags})
    apb(1'b1, `PMC_OFS_SUBMODE, 32'h1);
    `CHK("sub lock", 2'h2, super_mode)
    apb(1'b0, `PMC_OFS_INT_STAT, 0);
    `CHK("stat", 33'hF, {q, irq})
    apb(1'b1, `PMC_OFS_INT_MASK, 0);
    apb(1'b1, `PMC_OFS_INT_STAT, 32'h7);
    apb(1'b1, `PMC_OFS_INT_MASK, 32'h7);
    apb(1'b0, `PMC_OFS_INT_STAT, 0);
    `CHK("cleared", 33'h0, {q, irq})
    stop_test();
  end
endmodule // cpu_privilege_mode_control_tb
`default_nettype wire
